// ===== src/sbcmc_pkg.sv
package sbcmc_pkg;

    // clock and serial link timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SPI_MAX_HZ = 2_000_000;
    localparam int unsigned HALF_CYCLES =
        (CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
    localparam int unsigned HALF_W = 5;
    localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_CYCLES - 1);

    // frame layout
    localparam int unsigned FRAME_W = 16;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 4;
    localparam int unsigned ADDR_MSB = 15;
    localparam int unsigned ADDR_LSB = 10;
    localparam int unsigned RW_MSB = 9;
    localparam int unsigned RW_LSB = 8;
    localparam int unsigned PAR_MSB = 7;
    localparam int unsigned PAR_LSB = 4;
    localparam int unsigned DATA_MSB = 3;
    localparam int unsigned DATA_LSB = 0;
    localparam logic [1:0] RW_WRITE = 2'h3;
    localparam logic [1:0] RW_READ = 2'h0;
    localparam logic [4:0] BITS_PER_FRAME = 5'h10;

    // device register addresses
    localparam logic [ADDR_W-1:0] ADDR_MODE_CONTROL = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_MODE_VALIDATION = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_WATCHDOG_CONTROL = 6'h09;

    // user command codes
    typedef enum logic [2:0] {
        SBCMC_OP_WRITE = 3'h0,
        SBCMC_OP_READ = 3'h1,
        SBCMC_OP_MODE = 3'h2,
        SBCMC_OP_WDOG = 3'h3,
        SBCMC_OP_WAKE = 3'h4
    } sbcmc_op_t;

    // reset values
    localparam logic [FRAME_W-1:0] FRAME_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

    function automatic logic [DATA_W-1:0] parity(
        input logic [DATA_W-1:0] d
    );
        parity = {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]};
    endfunction

endpackage

// ===== src/sbcmc_tick.sv
`timescale 1ns/1ps
module sbcmc_tick (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic tick_o
);

    logic [sbcmc_pkg::HALF_W-1:0] cnt;
    logic [sbcmc_pkg::HALF_W-1:0] next_cnt;
    logic next_tick;

    // half-period timer, restarts whenever run drops
    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!run_i) begin
            next_cnt = '0;
        end else if (cnt == sbcmc_pkg::HALF_LAST) begin
            next_cnt = '0;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + sbcmc_pkg::HALF_W'(1);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end

endmodule

// ===== src/sbcmc_host.sv
`timescale 1ns/1ps
module sbcmc_host (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_op_i,
    input wire logic [5:0] cmd_addr_i,
    input wire logic [3:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic rsp_valid_o,
    output logic [3:0] rsp_data_o,
    output logic rsp_parity_err_o,
    output logic [15:0] rsp_frame_o,
    output logic sclk_o,
    output logic chip_select_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic reset_out_n_i,
    output logic dev_reset_n_o
);

    typedef enum logic [5:0] {
        SBCMC_IDLE = 6'h01,
        SBCMC_SETUP = 6'h02,
        SBCMC_HIGH = 6'h04,
        SBCMC_LOW = 6'h08,
        SBCMC_GAP = 6'h10,
        SBCMC_WAKE = 6'h20
    } sbcmc_state_t;

    sbcmc_state_t state;
    sbcmc_state_t next_state;
    logic tick;
    logic [15:0] tx;
    logic [15:0] next_tx;
    logic [15:0] rx;
    logic [15:0] next_rx;
    logic [4:0] bitcnt;
    logic [4:0] next_bitcnt;
    logic is_read;
    logic next_is_read;
    logic second_pending;
    logic next_second_pending;
    logic [3:0] mode_data;
    logic [3:0] next_mode_data;
    logic next_ready;
    logic next_done;
    logic next_rsp_valid;
    logic [3:0] next_rsp_data;
    logic next_rsp_parity_err;
    logic [15:0] next_rsp_frame;
    logic next_sclk;
    logic next_cs_n;
    logic next_mosi;

    // input synchronisers
    logic [2:0] miso_sync;
    logic miso_f;
    logic next_miso_f;
    logic [2:0] rst_sync;
    logic next_dev_rst;

    sbcmc_tick u_tick (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .run_i(state != SBCMC_IDLE),
        .tick_o(tick)
    );

    // build one frame
    function automatic logic [15:0] make_frame(
        input logic [5:0] addr,
        input logic rd,
        input logic [3:0] data
    );
        logic [15:0] f;
        f = '0;
        f[sbcmc_pkg::ADDR_MSB:sbcmc_pkg::ADDR_LSB] = addr;
        f[sbcmc_pkg::RW_MSB:sbcmc_pkg::RW_LSB] =
            rd ? sbcmc_pkg::RW_READ : sbcmc_pkg::RW_WRITE;
        f[sbcmc_pkg::PAR_MSB:sbcmc_pkg::PAR_LSB] =
            sbcmc_pkg::parity(data);
        f[sbcmc_pkg::DATA_MSB:sbcmc_pkg::DATA_LSB] = data;
        make_frame = f;
    endfunction

    // pin filters: change accepted when stages two and three agree
    always_comb begin
        next_miso_f = miso_f;
        next_dev_rst = dev_reset_n_o;
        if (miso_sync[1] == miso_sync[2]) begin
            next_miso_f = miso_sync[2];
        end
        if (rst_sync[1] == rst_sync[2]) begin
            next_dev_rst = rst_sync[2];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            miso_sync <= 3'h0;
            miso_f <= 1'b0;
            rst_sync <= 3'h0;
            dev_reset_n_o <= 1'b0;
        end else begin
            miso_sync <= {miso_sync[1:0], miso_i};
            miso_f <= next_miso_f;
            rst_sync <= {rst_sync[1:0], reset_out_n_i};
            dev_reset_n_o <= next_dev_rst;
        end
    end

    // transfer sequencer
    always_comb begin
        next_state = state;
        next_tx = tx;
        next_rx = rx;
        next_bitcnt = bitcnt;
        next_is_read = is_read;
        next_second_pending = second_pending;
        next_mode_data = mode_data;
        next_ready = cmd_ready_o;
        next_done = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data_o;
        next_rsp_parity_err = rsp_parity_err_o;
        next_rsp_frame = rsp_frame_o;
        next_sclk = sclk_o;
        next_cs_n = chip_select_n_o;
        next_mosi = mosi_o;
        case (state)
            SBCMC_IDLE: begin
                if (cmd_valid_i && cmd_ready_o) begin
                    next_ready = 1'b0;
                    next_cs_n = 1'b0;
                    next_sclk = 1'b0;
                    next_bitcnt = '0;
                    next_rx = '0;
                    next_is_read = 1'b0;
                    next_second_pending = 1'b0;
                    next_mode_data = cmd_data_i;
                    next_state = SBCMC_SETUP;
                    case (cmd_op_i)
                        sbcmc_pkg::SBCMC_OP_READ: begin
                            next_is_read = 1'b1;
                            next_tx = make_frame(cmd_addr_i, 1'b1,
                                sbcmc_pkg::DATA_RST);
                        end
                        sbcmc_pkg::SBCMC_OP_MODE: begin
                            next_second_pending = 1'b1;
                            next_tx = make_frame(
                                sbcmc_pkg::ADDR_MODE_CONTROL, 1'b0,
                                cmd_data_i);
                        end
                        sbcmc_pkg::SBCMC_OP_WDOG: begin
                            next_tx = make_frame(
                                sbcmc_pkg::ADDR_WATCHDOG_CONTROL, 1'b0,
                                cmd_data_i);
                        end
                        sbcmc_pkg::SBCMC_OP_WAKE: begin
                            next_tx = '0;
                            next_state = SBCMC_WAKE;
                        end
                        default: begin
                            next_tx = make_frame(cmd_addr_i, 1'b0,
                                cmd_data_i);
                        end
                    endcase
                    next_mosi = next_tx[sbcmc_pkg::FRAME_W-1];
                end
            end
            SBCMC_SETUP: begin
                if (tick) begin
                    next_sclk = 1'b1;
                    next_state = SBCMC_HIGH;
                end
            end
            SBCMC_HIGH: begin
                if (tick) begin
                    // device samples mosi on this fall
                    next_sclk = 1'b0;
                    next_rx = {rx[14:0], miso_f};
                    next_bitcnt = bitcnt + 5'h01;
                    next_state = SBCMC_LOW;
                end
            end
            SBCMC_LOW: begin
                if (tick) begin
                    if (bitcnt == sbcmc_pkg::BITS_PER_FRAME) begin
                        next_cs_n = 1'b1;
                        next_rsp_frame = rx;
                        if (is_read) begin
                            next_rsp_data = rx[sbcmc_pkg::DATA_MSB:
                                sbcmc_pkg::DATA_LSB];
                            next_rsp_parity_err =
                                rx[sbcmc_pkg::PAR_MSB:sbcmc_pkg::PAR_LSB]
                                != sbcmc_pkg::parity(rx[3:0]);
                            next_rsp_valid = 1'b1;
                        end
                        // write echo is stale; it goes to rsp_frame_o only, without rsp_valid_o or rsp_data_o
                        next_state = SBCMC_GAP;
                    end else begin
                        next_tx = {tx[14:0], 1'b0};
                        next_mosi = tx[14];
                        next_sclk = 1'b1;
                        next_state = SBCMC_HIGH;
                    end
                end
            end
            SBCMC_WAKE: begin
                if (tick) begin
                    next_cs_n = 1'b1;
                    next_state = SBCMC_GAP;
                end
            end
            SBCMC_GAP: begin
                if (tick) begin
                    if (second_pending) begin
                        next_second_pending = 1'b0;
                        next_tx = make_frame(
                            sbcmc_pkg::ADDR_MODE_VALIDATION, 1'b0,
                            mode_data);
                        next_mosi = next_tx[sbcmc_pkg::FRAME_W-1];
                        next_cs_n = 1'b0;
                        next_bitcnt = '0;
                        next_rx = '0;
                        next_state = SBCMC_SETUP;
                    end else begin
                        next_done = 1'b1;
                        next_ready = 1'b1;
                        next_state = SBCMC_IDLE;
                    end
                end
            end
            default: begin
                next_state = SBCMC_IDLE;
                next_cs_n = 1'b1;
                next_sclk = 1'b0;
                next_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= SBCMC_IDLE;
            tx <= sbcmc_pkg::FRAME_RST;
            rx <= sbcmc_pkg::FRAME_RST;
            bitcnt <= 5'h00;
            is_read <= 1'b0;
            second_pending <= 1'b0;
            mode_data <= sbcmc_pkg::DATA_RST;
            cmd_ready_o <= 1'b1;
            done_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= sbcmc_pkg::DATA_RST;
            rsp_parity_err_o <= 1'b0;
            rsp_frame_o <= sbcmc_pkg::FRAME_RST;
            sclk_o <= 1'b0;
            chip_select_n_o <= 1'b1;
            mosi_o <= 1'b0;
        end else begin
            state <= next_state;
            tx <= next_tx;
            rx <= next_rx;
            bitcnt <= next_bitcnt;
            is_read <= next_is_read;
            second_pending <= next_second_pending;
            mode_data <= next_mode_data;
            cmd_ready_o <= next_ready;
            done_o <= next_done;
            rsp_valid_o <= next_rsp_valid;
            rsp_data_o <= next_rsp_data;
            rsp_parity_err_o <= next_rsp_parity_err;
            rsp_frame_o <= next_rsp_frame;
            sclk_o <= next_sclk;
            chip_select_n_o <= next_cs_n;
            mosi_o <= next_mosi;
        end
    end

endmodule

// ===== tb/sbcmc_host_sva.sv
`timescale 1ns/1ps
module sbcmc_host_sva (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire logic rsp_valid_o,
    input wire logic done_o,
    input wire logic sclk_o,
    input wire logic chip_select_n_o,
    input wire logic mosi_o,
    input wire logic reset_out_n_i,
    input wire logic dev_reset_n_o
);
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic sclk_q;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // rising clock edges inside a frame
    always_comb begin
        next_cnt = cnt;
        if (chip_select_n_o) begin
            next_cnt = 5'h00;
        end else if (sclk_o && !sclk_q) begin
            next_cnt = cnt + 5'h01;
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 5'h00;
            sclk_q <= 1'b0;
        end else begin
            cnt <= next_cnt;
            sclk_q <= sclk_o;
        end
    end
    sequence s_high13;
        sclk_o [*8] ##1 sclk_o [*5];
    endsequence
    AST_SCLK_HALF: assert property ($rose(sclk_o) |-> s_high13 ##1 !sclk_o)
        else $error("sclk high phase not 13 cycles");
    AST_SCLK_IDLE: assert property (chip_select_n_o |-> !sclk_o)
        else $error("sclk high while deselected");
    AST_CS_SCLK_LOW: assert property ($changed(chip_select_n_o)
        |-> !sclk_o && !$past(sclk_o))
        else $error("select changed with sclk high");
    AST_MOSI_HOLD: assert property ($fell(sclk_o)
        |-> $stable(mosi_o) ##1 $stable(mosi_o))
        else $error("mosi moved at falling edge");
    AST_FRAME_LEN: assert property ($rose(chip_select_n_o)
        |-> cnt == 5'h10 || cnt == 5'h00)
        else $error("frame not sixteen clocks");
    AST_TAKE: assert property (cmd_valid_i && cmd_ready_o
        |=> !cmd_ready_o && !chip_select_n_o)
        else $error("command not started");
    AST_RSP_DONE: assert property (rsp_valid_o |-> chip_select_n_o
        ##1 !rsp_valid_o ##[10:16] done_o)
        else $error("read result out of sequence");
    AST_DEVRST: assert property ($fell(reset_out_n_i)
        |-> ##[1:6] !dev_reset_n_o)
        else $error("device reset not followed");
endmodule
bind sbcmc_host sbcmc_host_sva sbcmc_host_sva_i (.mclk_i, .rst_n_i,
    .cmd_valid_i, .cmd_ready_o, .rsp_valid_o, .done_o, .sclk_o,
    .chip_select_n_o, .mosi_o, .reset_out_n_i, .dev_reset_n_o);

// ===== tb/sbcmc_dev_model.sv
`timescale 1ns/1ps
module sbcmc_dev_model #(
    parameter logic [3:0] MODE_SLEEP = 4'h4,
    parameter int RST_CYC = 40,
    parameter int WD_TO = 3000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic reset_out_n_o,
    output logic [3:0] mode_o,
    output logic [7:0] wdog_cnt_o
);
    logic [3:0] regs [64];
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] last;
    logic [3:0] d;
    logic asleep;
    logic skip;
    logic wd_ok;
    int nbit;
    int rcnt;
    int wcnt;
    function automatic logic [3:0] par(input logic [3:0] v);
        par = {v[3] ^ v[0], v[3] ^ v[2], v[2] ^ v[1], v[1] ^ v[0]};
    endfunction
    assign reset_out_n_o = !asleep && rcnt == 0;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rcnt = RST_CYC;
            asleep = 1'b0;
            mode_o = 4'h0;
            wdog_cnt_o = 8'h00;
            last = 16'h0000;
            miso_o = 1'b0;
            nbit = 0;
            skip = 1'b0;
            wd_ok = 1'b0;
            wcnt = 0;
        end else begin
            if (rcnt > 0) begin
                rcnt--;
            end
            // startup pending watchdog
            if (asleep || rcnt > 0 || wd_ok || mode_o != 4'h0) begin
                wcnt = 0;
            end else if (wcnt == WD_TO) begin
                rcnt = RST_CYC;
                wcnt = 0;
            end else begin
                wcnt++;
            end
        end
    end
    always @(negedge chip_select_n_i) begin
        skip = asleep;
        if (asleep) begin
            asleep = 1'b0;
            mode_o = 4'h0;
            wd_ok = 1'b0;
            rcnt = RST_CYC;
        end
        tx = last;
        nbit = 0;
    end
    always @(posedge sclk_i) begin
        if (!chip_select_n_i && !asleep && !skip) begin
            miso_o = tx[15];
            tx = {tx[14:0], 1'b0};
        end
    end
    always @(negedge sclk_i) begin
        if (!chip_select_n_i && !asleep && !skip) begin
            rx = {rx[14:0], mosi_i};
            nbit++;
            if (nbit == 8 && rx[1:0] == 2'h0) begin
                d = rx[7:2] == 6'h00 ? mode_o : regs[rx[7:2]];
                tx[15:8] = {par(d), d};
            end
        end
    end
    always @(posedge chip_select_n_i) begin
        miso_o = ~miso_o;
        if (!asleep && nbit == 16) begin
            last = rx;
            if (rx[9:8] == 2'h3 && rx[7:4] == par(rx[3:0])) begin
                regs[rx[15:10]] = rx[3:0];
                if (rx[15:10] == 6'h09) begin
                    wdog_cnt_o++;
                    wd_ok = 1'b1;
                end
                if (rx[15:10] == 6'h03 && rx[3:0] == regs[0]) begin
                    mode_o = rx[3:0];
                    asleep = rx[3:0] == MODE_SLEEP;
                end
            end
        end
    end
endmodule

// ===== tb/sbc_spi_mode_control_test.sv
`timescale 1ns/1ps
module sbc_spi_mode_control_test;
    localparam logic [3:0] M_NORM = 4'h1;
    localparam logic [3:0] M_SLEEP = 4'h4;
    localparam int WD_TO = 3000;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [2:0] cmd_op_i = 3'h0;
    logic [5:0] cmd_addr_i = 6'h00;
    logic [3:0] cmd_data_i = 4'h0;
    logic cmd_ready_o, done_o, rsp_valid_o, rsp_parity_err_o;
    logic [3:0] rsp_data_o, mode;
    logic [15:0] rsp_frame_o;
    logic sclk_o, chip_select_n_o, mosi_o, miso, rst_out_n, dev_reset_n_o;
    logic [7:0] wdog;
    int err_count = 0;
    int total_checks = 0;
    always #10 mclk_i = ~mclk_i;
    sbcmc_host sbcmc_host_i (.mclk_i, .rst_n_i, .cmd_valid_i, .cmd_op_i,
        .cmd_addr_i, .cmd_data_i, .cmd_ready_o, .done_o, .rsp_valid_o,
        .rsp_data_o, .rsp_parity_err_o, .rsp_frame_o, .sclk_o,
        .chip_select_n_o, .mosi_o, .miso_i(miso),
        .reset_out_n_i(rst_out_n), .dev_reset_n_o);
    sbcmc_dev_model #(.MODE_SLEEP(M_SLEEP), .RST_CYC(40), .WD_TO(WD_TO))
        sbcmc_dev_model_i (
        .mclk_i, .rst_n_i, .sclk_i(sclk_o), .chip_select_n_i(chip_select_n_o),
        .mosi_i(mosi_o), .miso_o(miso), .reset_out_n_o(rst_out_n),
        .mode_o(mode), .wdog_cnt_o(wdog));
    function automatic logic [3:0] pexp(input logic [3:0] v);
        pexp = {v[3] ^ v[0], v[3] ^ v[2], v[2] ^ v[1], v[1] ^ v[0]};
    endfunction
    task automatic check(input string n, input logic [15:0] e,
        input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input sbcmc_pkg::sbcmc_op_t op, input logic [5:0] a,
        input logic [3:0] dv);
        int n;
        int v;
        logic rd;
        n = 0;
        v = 0;
        rd = op == sbcmc_pkg::SBCMC_OP_READ;
        cmd_op_i <= op;
        cmd_addr_i <= a;
        cmd_data_i <= dv;
        cmd_valid_i <= 1'b1;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        do begin
            @(posedge mclk_i);
            n++;
            if (rsp_valid_o === 1'b1) begin
                v++;
            end
        end while (done_o !== 1'b1 && n < 3000);
        if (n >= 3000) check("done", 16'h1, 16'h0);
        check("rsp_valid", 16'(rd), 16'(v));
    endtask
    task automatic wait_rst_high();
        int n;
        n = 0;
        while (dev_reset_n_o !== 1'b1 && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
    endtask
    task automatic t_reset();
        check("ready", 16'h1, cmd_ready_o);
        check("cs_idle", 16'h1, chip_select_n_o);
        check("sclk_idle", 16'h0, sclk_o);
        check("rst_in", 16'h0, dev_reset_n_o);
        rst_n_i <= 1'b1;
        wait_rst_high();
        check("rst_rel", 16'h1, dev_reset_n_o);
        cmd(sbcmc_pkg::SBCMC_OP_WDOG, 6'h00, 4'h5);
        check("wdog_first", 16'h1, wdog);
    endtask
    task automatic t_wr_rd();
        cmd(sbcmc_pkg::SBCMC_OP_WRITE, 6'h05, 4'ha);
        cmd(sbcmc_pkg::SBCMC_OP_READ, 6'h05, 4'h0);
        check("rd_data", 16'ha, rsp_data_o);
        check("rd_perr", 16'h0, rsp_parity_err_o);
        check("rd_frm", {6'h05, 2'h3, pexp(4'ha), 4'ha}, rsp_frame_o);
        cmd(sbcmc_pkg::SBCMC_OP_WRITE, 6'h06, 4'h3);
        check("wr_echo", {6'h05, 2'h0, 8'h00}, rsp_frame_o);
    endtask
    task automatic t_parity();
        for (int i = 0; i < 16; i++) begin
            cmd(sbcmc_pkg::SBCMC_OP_WRITE, 6'h0c, 4'(i));
            cmd(sbcmc_pkg::SBCMC_OP_READ, 6'h0c, 4'h0);
            check("par_data", 16'(i), rsp_data_o);
            check("par_frm", {6'h0c, 2'h3, pexp(4'(i)), 4'(i)},
                rsp_frame_o);
        end
    endtask
    task automatic t_mode();
        cmd(sbcmc_pkg::SBCMC_OP_MODE, 6'h00, M_NORM);
        check("mode_norm", 16'(M_NORM), mode);
        cmd(sbcmc_pkg::SBCMC_OP_WDOG, 6'h00, 4'h5);
        check("wdog", 16'h2, wdog);
        cmd(sbcmc_pkg::SBCMC_OP_MODE, 6'h00, M_SLEEP);
        repeat (8) @(posedge mclk_i);
        check("rst_sleep", 16'h0, dev_reset_n_o);
        cmd(sbcmc_pkg::SBCMC_OP_WAKE, 6'h00, 4'h0);
        check("mode_wake", 16'h0, mode);
        check("rst_wake", 16'h0, dev_reset_n_o);
        wait_rst_high();
        check("rst_up", 16'h1, dev_reset_n_o);
        cmd(sbcmc_pkg::SBCMC_OP_MODE, 6'h00, M_SLEEP);
        check("mode_sleep", 16'(M_SLEEP), mode);
        cmd(sbcmc_pkg::SBCMC_OP_WRITE, 6'h05, 4'h1);
        wait_rst_high();
        cmd(sbcmc_pkg::SBCMC_OP_READ, 6'h05, 4'h0);
        check("sleep_wr", 16'ha, rsp_data_o);
    endtask
    task automatic t_wdog();
        int n;
        n = 0;
        wait_rst_high();
        while (dev_reset_n_o === 1'b1 && n < WD_TO + 200) begin
            @(posedge mclk_i);
            n++;
        end
        check("wd_timeout", 16'h0, dev_reset_n_o);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk_i);
        t_reset();
        t_wr_rd();
        t_parity();
        t_mode();
        t_wdog();
        report_and_stop();
    end
    initial begin
        #1_000_000;
        err_count++;
        report_and_stop();
    end
endmodule
